/* inc/autoneg_adv_consts.vh */
`ifndef AUTONEG_ADV_CONSTS_VH
`define AUTONEG_ADV_CONSTS_VH

// ********************************************************
// Register byte addresses on the bus
// ********************************************************
`define ADDR_W          8
`define OFF_CONTROL     8'h00
`define OFF_ADVERTISE   8'h04
`define OFF_STATUS      8'h08
`define OFF_OVERRIDE    8'h40

// ********************************************************
// Advertisement register fields
// ********************************************************
`define ADV_NEXT_PAGE   15
`define ADV_RSV_ACK     14
`define ADV_REM_FAULT   13
`define ADV_RSV_HI      12
`define ADV_RSV_LO      10
`define ADV_T4          9
`define ADV_TAF_HI      8
`define ADV_TAF_LO      5
`define ADV_SEL_HI      4
`define ADV_SEL_LO      0
`define TAF_W           4
`define SEL_W           5
`define RSV_W           3
`define TAF_RESET       4'hF
`define SEL_RESET       5'h01
`define RSV_RESET       3'h0
`define TAF_100_FULL    4'h8
`define TAF_100_HALF    4'h4
`define TAF_10_FULL     4'h2
`define TAF_10_HALF     4'h1

// ********************************************************
// Control, status and override fields
// ********************************************************
`define CTL_SPEED       13
`define CTL_AN_EN       12
`define CTL_RESTART     9
`define CTL_DUPLEX      8
`define OVR_CMD         15
`define STS_CAP_HI      14
`define STS_CAP_LO      11
`define STS_CAP_ALL     4'hF
`define STS_AN_ACT      5
`define STS_HW_MODE     1
`define STS_IDLE        0

`endif

/* logic/pin_sync2.v */
`timescale 1ns/10ps
module pin_sync2 #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input  wire             sys_clk_i,
	input  wire             rst_b_i,
	// Raw and synchronised levels
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] stable_reg;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
			always @(posedge sys_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_reg[g]   <= 1'b0;
					stable_reg[g] <= 1'b0;
				end else begin
					meta_reg[g]   <= async_i[g];
					stable_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = stable_reg;

endmodule

/* logic/autoneg_advertisement_reg.v */
// Notes on behaviour
// RULE_01: Bit 15 is read/write, resets to 0, and advertises next-page support when set.
// RULE_02: Reserved bits 14 and 12 to 10 always read back as zero.
// RULE_03: Writes to override-write bits are dropped unless the command override bit is 1.
// RULE_04: Software must write zero into every reserved bit whenever it writes this register.
// RULE_05: Remote fault goes to 1 on a local link fault, to 0 without one, and is sent out; the code lets a write set it to 1 with no fault.
// RULE_06: The 100Base-T4 bit is always 0 whatever the mode or writes.
// RULE_07: The four ability bits are read-only in hardware mode, override-write in software mode.
// RULE_08: Each ability bit set advertises that technology, clear advertises its absence.
// RULE_09: Hardware mode without negotiation goes to idle at the pin-selected speed and duplex.
// RULE_10: Hardware mode with negotiation advertises exactly one ability chosen by the pins.
// RULE_11: Software mode with negotiation off idles at control register speed and duplex.
// RULE_12: Software mode with negotiation on advertises the ability bits, all 1 by default.
// RULE_13: The status capability bits always report every capability, whatever is advertised.
// RULE_14: Software changing the ability bits must then restart negotiation to take effect.
// RULE_15: The selector field is override-write, defaults to 00001 and is sent in the word.
// RULE_16: With negotiation on, the link code word is built from this register's contents.
// RULE_17: Reset loads every field with its default before any access is served.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`include "autoneg_adv_consts.vh"
module autoneg_advertisement_reg (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        rst_b_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [1:0]  wb_sel_i,
	input  wire [15:0] wb_dat_i,
	output wire [15:0] wb_dat_o,
	output wire        wb_ack_o,
	// Strap pins
	input  wire        hardware_software_select_pin_i,
	input  wire        autoneg_select_pin_i,
	input  wire        speed_select_pin_i,
	input  wire        duplex_select_pin_i,
	// Local link monitor
	input  wire        link_fault_i,
	// Towards the link pulse logic
	output wire [15:0] link_code_word_o,
	output wire        autoneg_active_o,
	output wire        autoneg_restart_o,
	output wire        send_idles_o,
	output wire        forced_speed_o,
	output wire        forced_duplex_o,
	output wire [3:0]  aux_reserved_o
);

	// ********************************************************
	// Mode states
	// ********************************************************
	localparam [2:0] ST_INIT = 3'h1;
	localparam [2:0] ST_NEG  = 3'h2;
	localparam [2:0] ST_IDLE = 3'h4;

	// ********************************************************
	// Decoding helpers
	// ********************************************************
	function reg_hit;
		input [`ADDR_W-1:0] adr;
		input [`ADDR_W-1:0] off;
		begin
			reg_hit = (adr == off);
		end
	endfunction

	function [`TAF_W-1:0] taf_from_pins;
		input spd;
		input dpx;
		begin
			case ({spd, dpx})
				2'h3: taf_from_pins = `TAF_100_FULL;
				2'h2: taf_from_pins = `TAF_100_HALF;
				2'h1: taf_from_pins = `TAF_10_FULL;
				default: taf_from_pins = `TAF_10_HALF;
			endcase
		end
	endfunction

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	wire [3:0] pins_sync;
	wire       hardware_software_select_pin_s;
	wire       an_sel_s;
	wire       speed_s;
	wire       duplex_s;

	pin_sync2 #(
		.WIDTH (4)
	) u_pin_sync (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   ({hardware_software_select_pin_i, autoneg_select_pin_i,
		             speed_select_pin_i, duplex_select_pin_i}),
		.sync_o    (pins_sync)
	);

	assign hardware_software_select_pin_s  = pins_sync[3];
	assign an_sel_s = pins_sync[2];
	assign speed_s  = pins_sync[1];
	assign duplex_s = pins_sync[0];

	// Low on the strap means hardware mode
	wire hw_mode = ~hardware_software_select_pin_s;

	// ********************************************************
	// Register state
	// ********************************************************
	reg                next_page_reg;
	reg                rsv_ack_reg;
	reg                rem_fault_reg;
	reg [`RSV_W-1:0]   rsv_reg;
	reg [`TAF_W-1:0]   taf_reg;
	reg [`SEL_W-1:0]   sel_reg;
	reg                an_en_reg;
	reg                speed_reg;
	reg                duplex_reg;
	reg                override_reg;
	reg                fault_prev_reg;
	reg                restart_reg;
	reg [2:0]          state_reg;
	reg [2:0]          state_next;
	reg                ack_reg;
	reg [15:0]         rdata_reg;
	reg [15:0]         lcw_reg;
	reg                an_active_reg;
	reg                idle_reg;
	reg                fspeed_reg;
	reg                fduplex_reg;
	reg [3:0]          aux_reg;

	// ********************************************************
	// Bus access strobes
	// ********************************************************
	// Read data is caught on the take edge; a write commits on the ack edge
	wire req     = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire wr      = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;
	wire wr_lo   = wr & wb_sel_i[0];
	wire wr_hi   = wr & wb_sel_i[1];
	wire hit_adv = reg_hit(wb_adr_i, `OFF_ADVERTISE);
	wire hit_ctl = reg_hit(wb_adr_i, `OFF_CONTROL);
	wire hit_ovr = reg_hit(wb_adr_i, `OFF_OVERRIDE);
	wire cw_ok   = override_reg; // RULE_03

	wire an_eff  = hw_mode ? an_sel_s : an_en_reg;

	// ********************************************************
	// Readable views
	// ********************************************************
	wire [15:0] adv_view;
	wire [15:0] ctl_view;
	wire [15:0] sts_view;
	wire [15:0] ovr_view;

	assign adv_view = {next_page_reg,       // RULE_01
	                   1'b0,                // RULE_02
	                   rem_fault_reg,
	                   `RSV_RESET,          // RULE_02
	                   1'b0,                // RULE_06
	                   taf_reg,             // RULE_08
	                   sel_reg};            // RULE_15

	assign ctl_view = {2'h0, speed_reg, an_en_reg, 3'h0, duplex_reg, 8'h00};

	// Capabilities stay complete whatever is advertised
	assign sts_view = {1'b0, `STS_CAP_ALL, 5'h00, an_active_reg,
	                   3'h0, hw_mode, idle_reg}; // RULE_13

	assign ovr_view = {override_reg, 15'h0000};

	// ********************************************************
	// Advertisement register
	// ********************************************************
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			next_page_reg  <= 1'b0; // RULE_17
			rsv_ack_reg    <= 1'b0;
			rem_fault_reg  <= 1'b0;
			rsv_reg        <= `RSV_RESET;
			taf_reg        <= `TAF_RESET; // RULE_12
			sel_reg        <= `SEL_RESET; // RULE_15
			fault_prev_reg <= 1'b0;
		end else begin
			fault_prev_reg <= link_fault_i;
			if (wr_hi && hit_adv) begin
				next_page_reg <= wb_dat_i[`ADV_NEXT_PAGE]; // RULE_01
				if (cw_ok) begin
					rsv_ack_reg <= wb_dat_i[`ADV_RSV_ACK]; // RULE_03
					rsv_reg     <= wb_dat_i[`ADV_RSV_HI:`ADV_RSV_LO]; // RULE_03
				end
			end
			// Fault detection wins over a software write in the same cycle
			if (link_fault_i) begin
				rem_fault_reg <= 1'b1; // RULE_05
			end else if (wr_hi && hit_adv) begin
				rem_fault_reg <= wb_dat_i[`ADV_REM_FAULT];
			end else if (fault_prev_reg) begin
				rem_fault_reg <= 1'b0; // RULE_05
			end
			if (hw_mode) begin
				// Pins rule the field; without negotiation its value is unused
				if (an_sel_s) begin
					taf_reg <= taf_from_pins(speed_s, duplex_s); // RULE_10
				end
			end else if (cw_ok) begin
				// Ability bits straddle both byte lanes
				if (wr_hi && hit_adv) begin
					taf_reg[`TAF_W-1] <= wb_dat_i[`ADV_TAF_HI]; // RULE_07
				end
				if (wr_lo && hit_adv) begin
					taf_reg[`TAF_W-2:0] <= wb_dat_i[`ADV_TAF_HI-1:`ADV_TAF_LO]; // RULE_07
				end
			end
			if (wr_lo && hit_adv && cw_ok) begin
				sel_reg <= wb_dat_i[`ADV_SEL_HI:`ADV_SEL_LO]; // RULE_15
			end
		end
	end

	// ********************************************************
	// Control and override registers
	// ********************************************************
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			an_en_reg    <= 1'b1;
			speed_reg    <= 1'b1;
			duplex_reg   <= 1'b0;
			override_reg <= 1'b0;
			restart_reg  <= 1'b0;
		end else begin
			restart_reg <= 1'b0;
			if (wr_hi && hit_ctl) begin
				speed_reg <= wb_dat_i[`CTL_SPEED];
				an_en_reg <= wb_dat_i[`CTL_AN_EN];
				// Restart only means something in software mode
				restart_reg <= wb_dat_i[`CTL_RESTART] & ~hw_mode; // RULE_14
				duplex_reg  <= wb_dat_i[`CTL_DUPLEX];
			end
			if (wr_hi && hit_ovr) begin
				override_reg <= wb_dat_i[`OVR_CMD];
			end
		end
	end

	// ********************************************************
	// Negotiation mode sequencer
	// ********************************************************
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_INIT: begin
				if (an_eff) begin
					state_next = ST_NEG; // RULE_10
				end else begin
					state_next = ST_IDLE; // RULE_09
				end
			end
			ST_NEG: begin
				if (!an_eff || restart_reg) begin
					state_next = ST_INIT;
				end
			end
			ST_IDLE: begin
				if (an_eff) begin
					state_next = ST_INIT;
				end
			end
			default: begin
				state_next = ST_INIT;
			end
		endcase
	end

	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_INIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// ********************************************************
	// Link side outputs
	// ********************************************************
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lcw_reg       <= {1'b0, 2'h0, `RSV_RESET, 1'b0, `TAF_RESET, `SEL_RESET};
			an_active_reg <= 1'b0;
			idle_reg      <= 1'b0;
			fspeed_reg    <= 1'b0;
			fduplex_reg   <= 1'b0;
			aux_reg       <= 4'h0;
		end else begin
			// Word is captured every cycle; the pulse logic latches it per burst
			lcw_reg       <= adv_view; // RULE_16
			an_active_reg <= (state_reg == ST_NEG);
			idle_reg      <= (state_reg == ST_IDLE);
			if (hw_mode) begin
				fspeed_reg  <= speed_s; // RULE_09
				fduplex_reg <= duplex_s; // RULE_09
			end else begin
				fspeed_reg  <= speed_reg; // RULE_11
				fduplex_reg <= duplex_reg; // RULE_11
			end
			aux_reg <= {rsv_ack_reg, rsv_reg};
		end
	end

	// ********************************************************
	// Bus answer
	// ********************************************************
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 16'h0000;
		end else begin
			ack_reg <= req;
			if (req) begin
				// Unmapped words read as zero and still acknowledge
				case (wb_adr_i)
					`OFF_CONTROL:   rdata_reg <= ctl_view;
					`OFF_ADVERTISE: rdata_reg <= adv_view; // RULE_02
					`OFF_STATUS:    rdata_reg <= sts_view;
					`OFF_OVERRIDE:  rdata_reg <= ovr_view;
					default:        rdata_reg <= 16'h0000;
				endcase
			end
		end
	end

	// ********************************************************
	// Output drive
	// ********************************************************
	assign wb_dat_o          = rdata_reg;
	assign wb_ack_o          = ack_reg;
	assign link_code_word_o  = lcw_reg;
	assign autoneg_active_o  = an_active_reg;
	assign autoneg_restart_o = restart_reg;
	assign send_idles_o      = idle_reg;
	assign forced_speed_o    = fspeed_reg;
	assign forced_duplex_o   = fduplex_reg;
	assign aux_reserved_o    = aux_reg;

endmodule

/* verif/autoneg_adv_chk.sv */
`timescale 1ns/10ps
// ********************************************
// Port checker for the advertisement register
// ********************************************
module autoneg_adv_chk (
	input wire        sys_clk_i,
	input wire        rst_b_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [15:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        hardware_software_select_pin_i,
	input wire        autoneg_select_pin_i,
	input wire        link_fault_i,
	input wire [15:0] link_code_word_o,
	input wire        autoneg_active_o,
	input wire        autoneg_restart_o,
	input wire        send_idles_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	rsv_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 8'h04)
		|-> (wb_dat_o & 16'h5E00) == 16'h0000)
		else $error("reserved or T4 bit read as one");
	word_rsv_a: assert property ((link_code_word_o & 16'h5E00) == 16'h0000)
		else $error("reserved or T4 bit sent as one");
	caps_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == 8'h08)
		|-> wb_dat_o[14:11] == 4'hF)
		else $error("status capabilities not all set");
	fault_sent_a: assert property (link_fault_i |-> ##2 link_code_word_o[13])
		else $error("local fault not sent");
	fault_clear_a: assert property (($fell(link_fault_i) && !wb_cyc_i)
		##1 (!link_fault_i && !wb_cyc_i) [*3] |-> !link_code_word_o[13])
		else $error("fault bit not cleared");
	hw_onehot_a: assert property ((!hardware_software_select_pin_i && autoneg_select_pin_i) [*8]
		|-> $onehot(link_code_word_o[8:5]))
		else $error("hardware mode ability not one-hot");
	idle_excl_a: assert property (!(send_idles_o && autoneg_active_o))
		else $error("idle and negotiate together");
	restart_cause_a: assert property (autoneg_restart_o
		|-> ($past(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h00))
		else $error("restart without control write");
endmodule

bind autoneg_advertisement_reg autoneg_adv_chk chk_i (.sys_clk_i, .rst_b_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .hardware_software_select_pin_i,
	.autoneg_select_pin_i, .link_fault_i, .link_code_word_o, .autoneg_active_o,
	.autoneg_restart_o, .send_idles_o);

/* verif/mgmt_station.sv */
`timescale 1ns/10ps
// ********************************************
// Management station, classic bus master
// ********************************************
module mgmt_station (
	input  wire        sys_clk_i,
	input  wire        wb_ack_i,
	input  wire [15:0] wb_dat_i,
	output reg         wb_cyc_o = 1'b0,
	output reg         wb_stb_o = 1'b0,
	output reg         wb_we_o  = 1'b0,
	output reg  [7:0]  wb_adr_o = 8'h00,
	output reg  [1:0]  wb_sel_o = 2'h3,
	output reg  [15:0] wb_dat_o = 16'h0000
);
	// Raw lets a scenario break the reserved-bit habit on purpose
	task automatic xfer(input bit we, input logic [7:0] adr, input logic [15:0] d,
		input bit raw, output logic [15:0] q, output bit ok);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_dat_o <= (adr == 8'h04 && !raw) ? (d & 16'hA3FF) : d;
		@(posedge sys_clk_i);
		while (wb_ack_i !== 1'b1 && n < 50) begin
			@(posedge sys_clk_i);
			n++;
		end
		q = wb_dat_i;
		ok = (n < 50);
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
	endtask
endmodule

/* verif/autoneg_advertisement_reg_bench.sv */
`timescale 1ns/10ps
// ********************************************
// Self-checking bench
// ********************************************
module autoneg_advertisement_reg_bench;
	logic        sys_clk_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic        hw_pin    = 1'b1;
	logic        an_pin    = 1'b0;
	logic        spd_pin   = 1'b1;
	logic        dpx_pin   = 1'b0;
	logic        fault     = 1'b0;
	wire         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	wire  [7:0]  wb_adr_i;
	wire  [1:0]  wb_sel_i;
	wire  [15:0] wb_dat_i, wb_dat_o, link_code_word_o;
	wire         autoneg_active_o, autoneg_restart_o, send_idles_o;
	wire         forced_speed_o, forced_duplex_o;
	wire  [3:0]  aux_reserved_o;
	int          n_errors = 0;
	int          checks_done = 0;
	int          n_restart = 0;
	logic [15:0] q;

	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (autoneg_restart_o === 1'b1) n_restart <= n_restart + 1;

	mgmt_station st (.sys_clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
		.wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
		.wb_dat_o(wb_dat_i));
	autoneg_advertisement_reg uut (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.hardware_software_select_pin_i(hw_pin), .autoneg_select_pin_i(an_pin),
		.speed_select_pin_i(spd_pin), .duplex_select_pin_i(dpx_pin), .link_fault_i(fault),
		.link_code_word_o, .autoneg_active_o, .autoneg_restart_o, .send_idles_o,
		.forced_speed_o, .forced_duplex_o, .aux_reserved_o);

	task conclude;
		$display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input bit we, input logic [7:0] a, input logic [15:0] d, input bit raw);
		bit ok;
		st.xfer(we, a, d, raw, q, ok);
		if (!ok) begin
			n_errors++;
			$display("[FAIL] bus ack expected 1 seen 0");
			conclude();
		end
	endtask

	task do_reset;
		rst_b_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
	endtask

	task t_defaults;
		do_reset();
		chk("word default", link_code_word_o, 16'h01E1);
		bus(0, 8'h04, 0, 0);
		chk("adv default", q, 16'h01E1);
		bus(0, 8'h08, 0, 0);
		chk("status caps", q[14:11], 4'hF);
		bus(1, 8'h20, 16'hFFFF, 0);
		bus(0, 8'h20, 0, 0);
		chk("unmapped", q, 16'h0000);
		$display("test defaults done");
	endtask

	task t_override;
		bus(1, 8'h04, 16'hFC1E, 1);
		bus(0, 8'h04, 0, 0);
		chk("adv locked", q, 16'hA1E1);
		chk("aux locked", aux_reserved_o, 16'h0);
		bus(1, 8'h40, 16'h8000, 0);
		bus(1, 8'h04, 16'h7E02, 1);
		bus(0, 8'h04, 0, 0);
		chk("adv open", q, 16'h2002);
		chk("aux open", aux_reserved_o, 16'hF);
		bus(1, 8'h04, 16'hDD41, 0);
		bus(0, 8'h04, 0, 0);
		chk("adv next page", q, 16'h8141);
		chk("aux cleared", aux_reserved_o, 16'h0);
		chk("word content", link_code_word_o, 16'h8141);
		bus(1, 8'h00, 16'h3200, 0);
		repeat (4) @(posedge sys_clk_i);
		chk("restart count", n_restart[15:0], 16'h1);
		chk("negotiating", autoneg_active_o, 1'b1);
		$display("test override done");
	endtask

	task t_fault;
		fault <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		bus(1, 8'h04, 16'h0141, 0);
		bus(0, 8'h04, 0, 0);
		chk("fault held", q[13], 1'b1);
		chk("fault sent", link_code_word_o[13], 1'b1);
		fault <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		bus(0, 8'h04, 0, 0);
		chk("fault cleared", q[13], 1'b0);
		$display("test fault done");
	endtask

	task t_modes;
		bus(1, 8'h00, 16'h0100, 0);
		repeat (4) @(posedge sys_clk_i);
		chk("sw idle", {send_idles_o, autoneg_active_o}, 16'h2);
		chk("sw forced", {forced_speed_o, forced_duplex_o}, 16'h1);
		for (int i = 0; i < 4; i++) begin
			hw_pin <= 1'b0;
			an_pin <= 1'b1;
			spd_pin <= i[1];
			dpx_pin <= i[0];
			do_reset();
			bus(0, 8'h04, 0, 0);
			chk("hw ability", q[8:5], 4'h1 << i);
			bus(1, 8'h40, 16'h8000, 0);
			bus(1, 8'h04, 16'h01E1, 0);
			bus(0, 8'h04, 0, 0);
			chk("hw locked", q[8:5], 4'h1 << i);
			bus(0, 8'h08, 0, 0);
			chk("hw caps", q[14:11], 4'hF);
		end
		an_pin <= 1'b0;
		dpx_pin <= 1'b0;
		do_reset();
		chk("hw idle", {send_idles_o, autoneg_active_o}, 16'h2);
		chk("hw forced", {forced_speed_o, forced_duplex_o}, 16'h2);
		$display("test modes done");
	endtask

	initial begin
		t_defaults();
		t_override();
		t_fault();
		t_modes();
		conclude();
	end
endmodule
